// File: fmt_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the tuning sequencer
// Assumes: 25 MHz system clock, registers one byte wide, one aligned word per register
// Notes:   Times are given in microseconds except pause durations, cycle counts are derived from them
`ifndef FMT_MAP_SVH
`define FMT_MAP_SVH

// Register indexes, byte address is four times the index
`define FMT_IDX_FLAGS      4'h0
`define FMT_IDX_MASK       4'h1
`define FMT_IDX_FSET_HIGH  4'h2
`define FMT_IDX_FSET_LOW   4'h3
`define FMT_IDX_CTRL_ONE   4'h4
`define FMT_IDX_CTRL_TWO   4'h5
`define FMT_IDX_FCHK_HIGH  4'h6
`define FMT_IDX_FCHK_LOW   4'h7
`define FMT_IDX_IF_RES     4'h8
`define FMT_IDX_LEVEL_RES  4'h9

// Flag and mask byte fields
`define FMT_F_BAND_LIMIT   0
`define FMT_F_TUNE_READY   1
`define FMT_F_PAUSE        2
`define FMT_F_LEVEL        3
`define FMT_F_IF_COUNT     4

// High frequency-set byte fields
`define FMT_B_SEARCH_SEL   7

// Tuner control one fields
`define FMT_B_AUDIO_MUTE   0
`define FMT_B_SEARCH_DIR   1
`define FMT_B_STOP_LVL     2
`define FMT_B_INJ_SIDE     4
`define FMT_B_AUTO_SIDE    5
`define FMT_B_BAND_JAPAN   6
`define FMT_B_RDS_UPDATE   7

// Tuner control two fields
`define FMT_B_HARD_MUTE    0
`define FMT_B_PAUSE_LVL    1
`define FMT_B_PAUSE_TIME   3

// Reset values
`define FMT_RST_FSET       14'h036b
`define FMT_RST_CTRL_ONE   8'h00
`define FMT_RST_CTRL_TWO   8'h00

// Band limits in 100 kHz raster units
`define FMT_BAND_EU_LOW    14'h036b
`define FMT_BAND_EU_HIGH   14'h0438
`define FMT_BAND_JP_LOW    14'h02f8
`define FMT_BAND_JP_HIGH   14'h0384

// IF offset limits in kHz
`define FMT_OFS_SEARCH_KHZ 5'h0c
`define FMT_OFS_PRESET_KHZ 5'h08

// Pause detector threshold base and step in dB
`define FMT_PAUSE_BASE_DB  8'h10
`define FMT_PAUSE_STEP_DB  8'h04

// Times in microseconds and derived cycle counts
`define FMT_CLK_MHZ        25
`define FMT_HOLD_US        15000
`define FMT_LEVEL_US       500
`define FMT_IF_UPD_US      30600
`define FMT_RDS_DWELL_US   2000
`define FMT_PRESET_DWELL_US 15600
`define FMT_STEP_DWELL_US  2000
`define FMT_HOLD_CYC       (`FMT_HOLD_US * `FMT_CLK_MHZ)
`define FMT_LEVEL_CYC      (`FMT_LEVEL_US * `FMT_CLK_MHZ)
`define FMT_IF_UPD_CYC     (`FMT_IF_UPD_US * `FMT_CLK_MHZ)
`define FMT_RDS_DWELL_CYC  (`FMT_RDS_DWELL_US * `FMT_CLK_MHZ)
`define FMT_PRESET_DWELL_CYC (`FMT_PRESET_DWELL_US * `FMT_CLK_MHZ)
`define FMT_STEP_DWELL_CYC (`FMT_STEP_DWELL_US * `FMT_CLK_MHZ)

// Minimum pause durations in reference clock periods
`define FMT_PAUSE_T0       16'h0028
`define FMT_PAUSE_T1       16'h0050
`define FMT_PAUSE_T2       16'h00a0
`define FMT_PAUSE_T3       16'h0140

`endif

// File: fmt_pkg.sv
// Purpose: Types shared by the tuning sequencer files
// Assumes: Nothing beyond the map header
// Notes:   State codes step in Gray order along the path through ST_RETURN
package fmt_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_MEASURE = 3'b001,
    ST_RETURN  = 3'b011,
    ST_FINISH  = 3'b010
  } tune_state_t;

  typedef enum logic [1:0] {
    KIND_PRESET = 2'b00,
    KIND_SEARCH = 2'b01,
    KIND_RDS    = 2'b10
  } tune_kind_t;

endpackage : fmt_pkg

// File: fmt_edge_sync.sv
// Purpose: Bring the reference clock into the system clock and mark its rising edges
// Assumes: Input is asynchronous to clk
// Notes:   Three flops; a change counts once the second and third agree
`timescale 1ns/1ps
`default_nettype none

module fmt_edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      rise
);

  logic [2:0] sync;
  logic       level;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], async_in};
    end
  end

  // Accept a new level only when the last two stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (sync[1] == sync[2] && sync[2] != level) begin
        level <= sync[2];
        rise  <= sync[2];
      end
    end
  end

endmodule : fmt_edge_sync

`default_nettype wire

// File: fm_tuning_search_sequencer.sv
// Purpose: Search, preset and alternative-frequency sequencer with mute and pause detector
// Assumes: Analog front end reports level, IF count, IF offset and audio level on clk
// Notes:   Register port is a plain strobe port, read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

`include "fmt_map.svh"

module fm_tuning_search_sequencer
  import fmt_pkg::*;
#(
  parameter int HOLD_CYC         = `FMT_HOLD_CYC,
  parameter int LEVEL_CYC        = `FMT_LEVEL_CYC,
  parameter int IF_UPD_CYC       = `FMT_IF_UPD_CYC,
  parameter int RDS_DWELL_CYC    = `FMT_RDS_DWELL_CYC,
  parameter int PRESET_DWELL_CYC = `FMT_PRESET_DWELL_CYC,
  parameter int STEP_DWELL_CYC   = `FMT_STEP_DWELL_CYC,
  parameter int CW               = 20
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        ref_clk_in,
  input  wire logic [3:0]  level_in,
  input  wire logic        if_ok_in,
  input  wire logic [4:0]  if_offset_khz,
  input  wire logic [6:0]  if_count_in,
  input  wire logic [7:0]  audio_db_in,
  output logic      [13:0] synth_freq,
  output logic             synth_load,
  output logic             injection_side,
  output logic             audio_mute_out,
  output logic             hard_mute_out,
  output logic             irq_out_n
);

  localparam logic [CW-1:0] HOLD_C   = CW'(HOLD_CYC);
  localparam logic [CW-1:0] LEVEL_C  = CW'(LEVEL_CYC);
  localparam logic [CW-1:0] IF_UPD_C = CW'(IF_UPD_CYC);
  localparam logic [CW-1:0] RDS_C    = CW'(RDS_DWELL_CYC);
  localparam logic [CW-1:0] PRESET_C = CW'(PRESET_DWELL_CYC);
  localparam logic [CW-1:0] STEP_C   = CW'(STEP_DWELL_CYC);

  // Register file
  logic [7:0]  irq_flag_byte;
  logic [7:0]  irq_mask_byte;
  logic [13:0] freq_set;
  logic        search_select;
  logic [7:0]  tuner_ctrl_one;
  logic [7:0]  tuner_ctrl_two;
  logic [13:0] freq_check;
  logic [6:0]  if_result_byte;
  logic [3:0]  level_result_byte;

  // Sequencer state
  tune_state_t state;
  tune_kind_t  kind;
  logic [CW-1:0] dwell_cnt;
  logic [CW-1:0] post_cnt;
  logic [13:0] orig_freq;
  logic        hold_mute;
  logic        done_bl;
  logic        done_if;

  // Pause detector
  logic        ref_tick;
  logic [15:0] pause_cnt;
  logic        pause_seen;

  // Decoded control bits
  logic       audio_mute;
  logic       search_direction;
  logic [1:0] stop_level;
  logic       auto_side_stop;
  logic       band_japan_sel;
  logic       hard_mute;
  logic [1:0] pause_level_sel;
  logic [1:0] pause_time_sel;

  assign audio_mute       = tuner_ctrl_one[`FMT_B_AUDIO_MUTE];
  assign search_direction = tuner_ctrl_one[`FMT_B_SEARCH_DIR];
  assign stop_level       = tuner_ctrl_one[`FMT_B_STOP_LVL +: 2];
  assign auto_side_stop   = tuner_ctrl_one[`FMT_B_AUTO_SIDE];
  assign band_japan_sel   = tuner_ctrl_one[`FMT_B_BAND_JAPAN];
  assign hard_mute        = tuner_ctrl_two[`FMT_B_HARD_MUTE];
  assign pause_level_sel  = tuner_ctrl_two[`FMT_B_PAUSE_LVL +: 2];
  assign pause_time_sel   = tuner_ctrl_two[`FMT_B_PAUSE_TIME +: 2];

  // Register strobes
  logic       addr_ok;
  logic [3:0] idx;
  logic       wr_fhigh;
  logic       trigger;
  logic       busy;

  assign addr_ok  = (addr[1:0] == 2'h0);
  assign idx      = addr[5:2];
  assign wr_fhigh = wr && addr_ok && idx == `FMT_IDX_FSET_HIGH;
  assign busy     = (state != ST_IDLE);
  assign trigger  = wr && addr_ok && !busy &&
                    (idx == `FMT_IDX_FSET_HIGH || idx == `FMT_IDX_FSET_LOW ||
                     idx == `FMT_IDX_CTRL_ONE  || idx == `FMT_IDX_CTRL_TWO);

  // Band edges and channel checks
  logic [13:0] band_low;
  logic [13:0] band_high;
  logic [3:0]  stop_adc;
  logic        level_ok;
  logic        if_valid;
  logic        at_limit;

  assign band_low  = band_japan_sel ? `FMT_BAND_JP_LOW  : `FMT_BAND_EU_LOW;
  assign band_high = band_japan_sel ? `FMT_BAND_JP_HIGH : `FMT_BAND_EU_HIGH;

  always_comb begin
    case (stop_level)
      2'h0:    stop_adc = 4'h3;
      2'h1:    stop_adc = 4'h5;
      2'h2:    stop_adc = 4'h7;
      default: stop_adc = 4'ha;
    endcase
  end

  assign level_ok = (level_in >= stop_adc);
  assign if_valid = if_ok_in && (if_offset_khz <= ((kind == KIND_SEARCH) ?
                    `FMT_OFS_SEARCH_KHZ : `FMT_OFS_PRESET_KHZ));
  assign at_limit = search_direction ? (synth_freq >= band_high)
                                     : (synth_freq <= band_low);

  // Next frequency for a search step, with the new frequency already loaded
  logic [13:0] next_freq;
  assign next_freq = search_direction ? synth_freq + 14'h0001
                                      : synth_freq - 14'h0001;

  // Control register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_byte  <= 8'h00;
      freq_set       <= `FMT_RST_FSET;
      search_select  <= 1'b0;
      tuner_ctrl_one <= `FMT_RST_CTRL_ONE;
      tuner_ctrl_two <= `FMT_RST_CTRL_TWO;
    end else if (wr && addr_ok) begin
      case (idx)
        `FMT_IDX_MASK:      irq_mask_byte <= wdata;
        `FMT_IDX_FSET_HIGH: begin
          search_select    <= wdata[`FMT_B_SEARCH_SEL];
          freq_set[13:8]   <= wdata[5:0];
        end
        `FMT_IDX_FSET_LOW:  freq_set[7:0] <= wdata;
        `FMT_IDX_CTRL_ONE:  tuner_ctrl_one <= wdata;
        `FMT_IDX_CTRL_TWO:  tuner_ctrl_two <= wdata;
        default: ;
      endcase
    end
  end

  // Injection side follows its control bit; a new frequency write retunes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      injection_side <= 1'b0;
    end else begin
      injection_side <= tuner_ctrl_one[`FMT_B_INJ_SIDE];
    end
  end

  // Tuning algorithm
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      kind       <= KIND_PRESET;
      dwell_cnt  <= '0;
      synth_freq <= `FMT_RST_FSET;
      synth_load <= 1'b0;
      orig_freq  <= `FMT_RST_FSET;
      hold_mute  <= 1'b0;
      done_bl    <= 1'b0;
      done_if    <= 1'b0;
    end else begin
      synth_load <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (trigger) begin
            orig_freq  <= synth_freq;
            hold_mute  <= 1'b0;
            synth_load <= 1'b1;
            state      <= ST_MEASURE;
            if (wr_fhigh ? wdata[`FMT_B_SEARCH_SEL] : search_select) begin
              kind      <= KIND_SEARCH;
              dwell_cnt <= STEP_C;
            end else if (tuner_ctrl_one[`FMT_B_RDS_UPDATE]) begin
              kind      <= KIND_RDS;
              dwell_cnt <= RDS_C;
            end else begin
              kind      <= KIND_PRESET;
              dwell_cnt <= PRESET_C;
            end
            // Start from the frequency being written in this same cycle
            if (idx == `FMT_IDX_FSET_HIGH) begin
              synth_freq <= {wdata[5:0], freq_set[7:0]};
            end else if (idx == `FMT_IDX_FSET_LOW) begin
              synth_freq <= {freq_set[13:8], wdata};
            end else begin
              synth_freq <= freq_set;
            end
          end
        end
        ST_MEASURE: begin
          if (dwell_cnt > 1) begin
            dwell_cnt <= dwell_cnt - 1'b1;
          end else begin
            case (kind)
              KIND_SEARCH: begin
                if (level_ok && if_valid) begin
                  done_bl <= at_limit;
                  done_if <= 1'b0;
                  state   <= ST_FINISH;
                end else if (level_ok && auto_side_stop) begin
                  done_bl   <= 1'b0;
                  done_if   <= 1'b1;
                  hold_mute <= 1'b1;
                  state     <= ST_FINISH;
                end else if (at_limit) begin
                  done_bl <= 1'b1;
                  done_if <= 1'b1;
                  state   <= ST_FINISH;
                end else begin
                  synth_freq <= next_freq;
                  synth_load <= 1'b1;
                  dwell_cnt  <= STEP_C;
                end
              end
              KIND_RDS: begin
                done_bl <= 1'b0;
                if (level_ok && if_valid) begin
                  done_if   <= 1'b0;
                  hold_mute <= 1'b1;
                  state     <= ST_FINISH;
                end else begin
                  done_if    <= 1'b1;
                  synth_freq <= orig_freq;
                  synth_load <= 1'b1;
                  state      <= ST_RETURN;
                end
              end
              default: begin
                done_bl   <= 1'b0;
                done_if   <= !if_valid;
                hold_mute <= auto_side_stop && level_ok && !if_valid;
                state     <= ST_FINISH;
              end
            endcase
          end
        end
        ST_RETURN: begin
          state <= ST_FINISH;
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Time since completion; events at the level and IF update points
  logic finish;
  logic level_evt;
  logic if_evt;
  logic frozen;

  assign finish    = (state == ST_FINISH);
  assign level_evt = (post_cnt == LEVEL_C - 1'b1);
  assign if_evt    = (post_cnt == IF_UPD_C - 1'b1);
  assign frozen    = busy || (post_cnt < HOLD_C);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      post_cnt <= IF_UPD_C;
    end else if (trigger) begin
      post_cnt <= IF_UPD_C;
    end else if (finish) begin
      post_cnt <= '0;
    end else if (post_cnt < IF_UPD_C) begin
      post_cnt <= post_cnt + 1'b1;
    end
  end

  // Status registers: freq_check held while frozen except at finish; level and IF results load when idle past their points
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      freq_check        <= `FMT_RST_FSET;
      if_result_byte    <= 7'h00;
      level_result_byte <= 4'h0;
    end else begin
      if (finish || !frozen) begin
        freq_check <= synth_freq;
      end
      if (!busy && post_cnt >= LEVEL_C - 1'b1) begin
        level_result_byte <= level_in;
      end
      if (!busy && post_cnt >= IF_UPD_C - 1'b1) begin
        if_result_byte <= if_count_in;
      end
    end
  end

  // Pause detector, timed on reference clock edges
  fmt_edge_sync u_ref_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (ref_clk_in),
    .rise     (ref_tick)
  );

  logic [7:0]  pause_thr;
  logic [15:0] pause_min;
  logic        pause_evt;

  assign pause_thr = `FMT_PAUSE_BASE_DB + `FMT_PAUSE_STEP_DB * {6'h00, pause_level_sel};

  always_comb begin
    case (pause_time_sel)
      2'h0:    pause_min = `FMT_PAUSE_T0;
      2'h1:    pause_min = `FMT_PAUSE_T1;
      2'h2:    pause_min = `FMT_PAUSE_T2;
      default: pause_min = `FMT_PAUSE_T3;
    endcase
  end

  assign pause_evt = ref_tick && !pause_seen && (pause_cnt + 16'h0001 >= pause_min);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pause_cnt  <= 16'h0000;
      pause_seen <= 1'b0;
    end else if (audio_db_in >= pause_thr) begin
      pause_cnt  <= 16'h0000;
      pause_seen <= 1'b0;
    end else if (ref_tick && !pause_seen) begin
      pause_cnt  <= pause_cnt + 16'h0001;
      pause_seen <= pause_evt;
    end
  end

  // Flags: hardware set wins over the clear caused by reading the flag byte
  logic        flag_clr;
  logic [7:0]  flag_set;

  assign flag_clr = rd && addr_ok && idx == `FMT_IDX_FLAGS;

  always_comb begin
    flag_set = 8'h00;
    flag_set[`FMT_F_TUNE_READY] = finish;
    flag_set[`FMT_F_BAND_LIMIT] = finish && done_bl;
    flag_set[`FMT_F_IF_COUNT]   = (finish && done_if) ||
                                  (if_evt && !busy && !if_ok_in);
    flag_set[`FMT_F_LEVEL]      = level_evt && !busy && !level_ok;
    flag_set[`FMT_F_PAUSE]      = pause_evt;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_flag_byte <= 8'h00;
    end else begin
      irq_flag_byte <= (flag_clr ? 8'h00 : irq_flag_byte) | flag_set;
    end
  end

  // Interrupt and mute outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_out_n      <= 1'b1;
      audio_mute_out <= 1'b0;
      hard_mute_out  <= 1'b0;
    end else begin
      irq_out_n      <= ~|(irq_flag_byte & irq_mask_byte);
      audio_mute_out <= audio_mute ||
                        (busy && kind != KIND_SEARCH) ||
                        (busy && auto_side_stop) ||
                        hold_mute;
      hard_mute_out  <= hard_mute;
    end
  end

  // Read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd && addr_ok) begin
      case (idx)
        `FMT_IDX_FLAGS:     rdata <= irq_flag_byte;
        `FMT_IDX_MASK:      rdata <= irq_mask_byte;
        `FMT_IDX_FSET_HIGH: rdata <= {search_select, 1'b0, freq_set[13:8]};
        `FMT_IDX_FSET_LOW:  rdata <= freq_set[7:0];
        `FMT_IDX_CTRL_ONE:  rdata <= tuner_ctrl_one;
        `FMT_IDX_CTRL_TWO:  rdata <= tuner_ctrl_two;
        `FMT_IDX_FCHK_HIGH: rdata <= {2'h0, freq_check[13:8]};
        `FMT_IDX_FCHK_LOW:  rdata <= freq_check[7:0];
        `FMT_IDX_IF_RES:    rdata <= {1'b0, if_result_byte};
        `FMT_IDX_LEVEL_RES: rdata <= {4'h0, level_result_byte};
        default:            rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : fm_tuning_search_sequencer

`default_nettype wire

// File: fmt_front_model.sv
// Purpose: Front end model with three stations and a free-running reference clock
// Assumes: Stations sit on the 100 kHz raster
// Notes:   Audio level is set by the bench
`timescale 1ns/1ps
`default_nettype none
module fmt_front_model #(
  parameter logic [13:0] ST_GOOD = 14'h0375,
  parameter logic [13:0] ST_BAD  = 14'h0372,
  parameter logic [13:0] ST_OFS  = 14'h0378
) (
  input  wire logic [13:0] synth_freq,
  input  wire logic [7:0]  audio_db,
  output logic             ref_clk_in,
  output logic [3:0]       level_in,
  output logic             if_ok_in,
  output logic [4:0]       if_offset_khz,
  output logic [6:0]       if_count_in,
  output logic [7:0]       audio_db_in
);
  initial ref_clk_in = 1'b0;
  always #160 ref_clk_in = ~ref_clk_in;
  always_comb begin
    level_in = (synth_freq inside {ST_GOOD, ST_BAD, ST_OFS}) ? 4'h9 : 4'h1;
    if_ok_in = synth_freq != ST_BAD;
    if_offset_khz = (synth_freq == ST_OFS) ? 5'h0a : 5'h02;
    if_count_in = if_ok_in ? 7'h3e : 7'h10;
    audio_db_in = audio_db;
  end
endmodule : fmt_front_model
`default_nettype wire

// File: fmt_checker.sv
// Purpose: Port checks of the tuning sequencer
// Assumes: Shadow bits track host writes
// Notes:   Bound to the sequencer
`timescale 1ns/1ps
`default_nettype none
module fmt_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [5:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic [13:0] synth_freq,
  input wire logic        synth_load,
  input wire logic        audio_mute_out,
  input wire logic        irq_out_n
);
  logic srch, afb, aside, mreg, acc;
  assign acc = rd | wr;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      srch <= 1'b0;
      {afb, aside, mreg} <= 3'h0;
    end else if (wr && addr == 6'h08) begin
      srch <= wdata[7];
    end else if (wr && addr == 6'h10) begin
      {afb, aside, mreg} <= {wdata[7], wdata[5], wdata[0]};
    end
  end
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  load_pulse_a: assert property (synth_load |=> !synth_load)
    else $error("load pulse too long");
  freq_steady_a: assert property (!synth_load |-> $stable(synth_freq))
    else $error("frequency moved without load");
  irq_hold_a: assert property (!irq_out_n && !acc && !$past(acc) && !$past(acc, 2)
    |=> !irq_out_n) else $error("interrupt dropped without host access");
  mute_bit_a: assert property (mreg && $past(mreg) |-> audio_mute_out)
    else $error("mute bit not honoured");
  preset_mute_a: assert property ($past(synth_load) && !srch && !afb |-> audio_mute_out)
    else $error("preset not muted");
  search_quiet_a: assert property ($past(synth_load) && srch && !mreg && !aside
    |-> !audio_mute_out) else $error("search muted");
  side_mute_a: assert property ($past(synth_load) && aside |-> audio_mute_out)
    else $error("side stop search not muted");
endmodule : fmt_checker
bind fm_tuning_search_sequencer fmt_checker u_chk (.clk, .rst_n, .addr, .wdata, .wr, .rd,
  .rdata, .synth_freq, .synth_load, .audio_mute_out, .irq_out_n);
`default_nettype wire

// File: test_fm_tuning_search_sequencer.sv
// Purpose: Self-checking bench of the tuning sequencer
// Assumes: Shortened dwell, level and IF update counts; hold count left at its default
// Notes:   Front end model supplies stations and reference clock
`timescale 1ns/1ps
`default_nettype none
module test_fm_tuning_search_sequencer;
  logic        clk, rst_n, wr, rd, ref_clk_in, if_ok_in, synth_load;
  logic        injection_side, audio_mute_out, hard_mute_out, irq_out_n;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata, audio_db_in, audio, f;
  logic [3:0]  level_in;
  logic [4:0]  if_offset_khz;
  logic [6:0]  if_count_in;
  logic [13:0] synth_freq;
  int          err_count, tests_run, cyc;
  fm_tuning_search_sequencer #(.LEVEL_CYC(20), .IF_UPD_CYC(600),
    .RDS_DWELL_CYC(10), .PRESET_DWELL_CYC(20), .STEP_DWELL_CYC(5)) dut (.clk, .rst_n,
    .addr, .wdata, .wr, .rd, .rdata, .ref_clk_in, .level_in, .if_ok_in, .if_offset_khz,
    .if_count_in, .audio_db_in, .synth_freq, .synth_load, .injection_side,
    .audio_mute_out, .hard_mute_out, .irq_out_n);
  fmt_front_model u_front (.synth_freq, .audio_db(audio), .ref_clk_in, .level_in,
    .if_ok_in, .if_offset_khz, .if_count_in, .audio_db_in);
  always #20 clk = ~clk;
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic check_bit(input logic got, input logic exp);
    check({13'h0000, got}, {13'h0000, exp});
  endtask : check_bit
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd_reg
  task automatic wait_irq;
    for (int n = 0; n < 3000 && irq_out_n !== 1'b0; n++) @(posedge clk);
    if (irq_out_n !== 1'b0) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, irq_out_n, 1'b0);
    end
  endtask : wait_irq
  task automatic tune(input logic [5:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] g;
    wr_reg(a, d);
    wait_irq();
    rd_reg(6'h00, g);
    if (e !== 8'hff) check({6'h00, g}, {6'h00, e});
    repeat (700) @(posedge clk);
    rd_reg(6'h00, g);
  endtask : tune
  task automatic ended(input string s);
    $display("test %s done", s);
  endtask : ended
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    {clk, rst_n, wr, rd, addr, wdata} = '0;
    audio = 8'h40;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(synth_freq, 14'h036b);
    rd_reg(6'h3c, f);
    check({6'h00, f}, 14'h0000);
    wr_reg(6'h04, 8'h02);
    tune(6'h0c, 8'h70, 8'h02);
    check(synth_freq, 14'h0370);
    wr_reg(6'h0c, 8'h75);
    tune(6'h0c, 8'h6b, 8'h02);
    check(synth_freq, 14'h0375);
    rd_reg(6'h1c, f);
    check({6'h00, f}, 14'h0075);
    rd_reg(6'h20, f);
    check({6'h00, f}, 14'h003e);
    rd_reg(6'h24, f);
    check({6'h00, f}, 14'h0009);
    tune(6'h10, 8'h02, 8'hff);
    tune(6'h08, 8'h83, 8'h02);
    check(synth_freq, 14'h0375);
    ended("preset and search");
    tune(6'h10, 8'h22, 8'h12);
    check(synth_freq, 14'h0372);
    check_bit(audio_mute_out, 1'b1);
    tune(6'h10, 8'h10, 8'h13);
    check(synth_freq, 14'h036b);
    check_bit(injection_side, 1'b1);
    ended("side stop and band limit");
    tune(6'h08, 8'h03, 8'hff);
    tune(6'h0c, 8'h78, 8'h12);
    tune(6'h10, 8'h80, 8'h12);
    tune(6'h0c, 8'h75, 8'h02);
    check_bit(audio_mute_out, 1'b1);
    tune(6'h0c, 8'h72, 8'h12);
    check(synth_freq, 14'h0375);
    ended("offset and alternative jump");
    tune(6'h0c, 8'h79, 8'h12);
    tune(6'h10, 8'h42, 8'hff);
    tune(6'h08, 8'h83, 8'h13);
    check(synth_freq, 14'h0384);
    tune(6'h10, 8'h01, 8'h02);
    check_bit(audio_mute_out, 1'b1);
    tune(6'h14, 8'h03, 8'hff);
    check_bit(hard_mute_out, 1'b1);
    wr_reg(6'h04, 8'h04);
    audio <= 8'h12;
    wait_irq();
    rd_reg(6'h00, f);
    check_bit(f[2], 1'b1);
    ended("mute and pause");
    test_done();
  end
endmodule : test_fm_tuning_search_sequencer
`default_nettype wire
